/* common/pis_map.vh */
`ifndef PIS_MAP_VH
`define PIS_MAP_VH
// Input counts
`define PIS_ISA_N 16
`define PIS_PCI_N 48
// PCI-side input indices
`define PIS_IDX_SCSI_B 2
`define PIS_IDX_GFX 32
`define PIS_IDX_SB_D 33
`define PIS_IDX_B1_A 34
`define PIS_IDX_SCSI_A 42
`define PIS_IDX_HOTPLUG 43
`define PIS_IDX_SYSBUS_ERR 44
`define PIS_IDX_A1_A 45
`define PIS_IDX_SB_NMI 46
`define PIS_IDX_UNUSED 47
// ISA-side input indices
`define PIS_ISA_CASCADE 0
`define PIS_ISA_IRQ1 1
`define PIS_ISA_IRQ0 2
`define PIS_ISA_IRQ8 8
// Configuration space
`define PIS_IDSEL_LINE 25
`define PIS_CFG_CTRL_DW 6'h10
`define PIS_CFG_PEND_LO_DW 6'h11
`define PIS_CFG_PEND_HI_DW 6'h12
`define PIS_CFG_ISA_DW 6'h13
`define PIS_CTRL_RST 32'h0000_0000
// Control field positions
`define PIS_CTRL_APIC 0
`define PIS_CTRL_SMI_SB_NMI 1
`define PIS_CTRL_SMI_PCIERR 2
`define PIS_CTRL_SMI_CECC 3
`define PIS_CTRL_SMI_UECC 4
`define PIS_CTRL_SMI_SB_SMI 5
`define PIS_CTRL_NMI_PCIERR 6
`define PIS_CTRL_NMI_UECC 7
`define PIS_CTRL_NMI_MGMT 8
`define PIS_CTRL_W 9
// PCI commands
`define PIS_CMD_CFG_RD 4'ha
`define PIS_CMD_CFG_WR 4'hb
`endif

/* rtl/pis_steer.v */
`timescale 1ns/10ps
`include "pis_map.vh"
module pis_steer (
   // Clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // PCI target (simplified, single-data-phase config cycles)
   input wire frame_n_i,
   input wire irdy_n_i,
   input wire idsel_i,
   input wire [3:0] cbe_n_i,
   input wire [31:0] ad_i,
   output wire [31:0] ad_o,
   output wire ad_oe_o,
   output wire trdy_n_o,
   output wire devsel_n_o,
   output wire ctl_oe_o,
   // PCI arbitration
   input wire gnt_n_i,
   output wire req_n_o,
   // Interrupt inputs, pins
   input wire [47:0] pci_int_n_i,
   input wire [15:0] isa_irq_i,
   input wire pci_serr_n_i,
   input wire pci_perr_n_i,
   input wire ecc_corr_i,
   input wire ecc_uncorr_i,
   input wire sb_smi_n_i,
   input wire mgmt_smi_n_i,
   // Processor side
   output wire intr_o,
   output wire [47:0] apic_pend_o,
   output wire [15:0] isa_pend_o,
   output wire smi_o,
   output wire nmi_o
);
   // Synchronised pins
   wire [47:0] pci_int_n_s;
   wire [15:0] isa_s;
   wire [5:0] misc_s;
   wire [5:0] misc_raw;
   assign misc_raw = {mgmt_smi_n_i, sb_smi_n_i, ecc_uncorr_i,
      ecc_corr_i, pci_perr_n_i, pci_serr_n_i};
   pis_sync #(.W(48)) u_sync_pci (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i(pci_int_n_i),
      .rst_val_i({48{1'b1}}),
      .sync_o(pci_int_n_s)
   );
   pis_sync #(.W(16)) u_sync_isa (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i(isa_irq_i),
      .rst_val_i(16'h0100),
      .sync_o(isa_s)
   );
   pis_sync #(.W(6)) u_sync_misc (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i(misc_raw),
      .rst_val_i(6'h33),
      .sync_o(misc_s)
   );

   // Positions inside the synchronised misc vector
   localparam M_SERR = 0;
   localparam M_PERR = 1;
   localparam M_CECC = 2;
   localparam M_UECC = 3;
   localparam M_SB_SMI = 4;
   localparam M_MGMT_SMI = 5;
   // Reset image of the control dword, cut to the implemented bits
   localparam [31:0] CTRL_RST = `PIS_CTRL_RST;

   // Control register
   reg [`PIS_CTRL_W-1:0] ctrl_q;
   reg [`PIS_CTRL_W-1:0] ctrl_d;
   reg [47:0] apic_pend_q;
   reg [15:0] isa_pend_q;
   reg intr_q;
   reg smi_q;
   reg nmi_q;

   // Pending vectors: level, pending only while source held
   wire [47:0] pci_act;
   genvar gi;
   generate
      for (gi = 0; gi < 48; gi = gi + 1) begin : g_pci
         // Each input is one level pin that sources may share; index 47 reads idle
         if (gi == `PIS_IDX_UNUSED) begin : g_unused
            assign pci_act[gi] = 1'b0;
         end else begin : g_used
            assign pci_act[gi] = ~pci_int_n_s[gi];
         end
      end
   endgenerate

   // ISA input 8 is active low; every other ISA input is active high
   wire [15:0] isa_act;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_isa
         if (gi == `PIS_ISA_IRQ8) begin : g_low
            assign isa_act[gi] = ~isa_s[gi];
         end else begin : g_high
            assign isa_act[gi] = isa_s[gi];
         end
      end
   endgenerate

   // Critical sources, all normalised to active high
   wire sb_nmi;
   wire pci_err;
   wire cecc;
   wire uecc;
   wire sb_smi;
   wire mgmt_smi;
   assign sb_nmi = pci_act[`PIS_IDX_SB_NMI];
   assign pci_err = ~misc_s[M_SERR] | ~misc_s[M_PERR];
   assign cecc = misc_s[M_CECC];
   assign uecc = misc_s[M_UECC];
   assign sb_smi = ~misc_s[M_SB_SMI];
   assign mgmt_smi = ~misc_s[M_MGMT_SMI];

   // One enable bit per route, so no source can mask another
   wire [4:0] smi_src;
   wire [4:0] smi_en;
   wire [2:0] nmi_src;
   wire [2:0] nmi_en;
   assign smi_src = {sb_smi, uecc, cecc, pci_err, sb_nmi};
   assign smi_en = {ctrl_q[`PIS_CTRL_SMI_SB_SMI],
      ctrl_q[`PIS_CTRL_SMI_UECC], ctrl_q[`PIS_CTRL_SMI_CECC],
      ctrl_q[`PIS_CTRL_SMI_PCIERR], ctrl_q[`PIS_CTRL_SMI_SB_NMI]};
   assign nmi_src = {mgmt_smi, uecc, pci_err};
   assign nmi_en = {ctrl_q[`PIS_CTRL_NMI_MGMT], ctrl_q[`PIS_CTRL_NMI_UECC],
      ctrl_q[`PIS_CTRL_NMI_PCIERR]};
   wire smi_d = |(smi_src & smi_en);
   // Direct path keeps fatal errors visible with the SMI handler off
   wire nmi_d = |(nmi_src & nmi_en);

   // Legacy style folds all PCI levels into the shared INTR line too
   wire apic_mode;
   wire legacy;
   wire intr_d;
   assign apic_mode = ctrl_q[`PIS_CTRL_APIC];
   assign legacy = ~apic_mode;
   assign intr_d = legacy & ((|isa_act) | (|pci_act));

   // Pending images; the pins are already synchronised
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         apic_pend_q <= 48'h0;
         isa_pend_q <= 16'h0;
      end else begin
         apic_pend_q <= apic_mode ? pci_act : 48'h0;
         isa_pend_q <= isa_act;
      end
   end

   // Processor lines
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         intr_q <= 1'b0;
         smi_q <= 1'b0;
         nmi_q <= 1'b0;
      end else begin
         intr_q <= intr_d;
         smi_q <= smi_d;
         nmi_q <= nmi_d;
      end
   end
   assign intr_o = intr_q;
   assign apic_pend_o = apic_pend_q;
   assign isa_pend_o = isa_pend_q;
   assign smi_o = smi_q;
   assign nmi_o = nmi_q;

   // Configuration target
   localparam ST_IDLE = 2'b00;
   localparam ST_DATA = 2'b01;
   localparam ST_TURN = 2'b10;
   reg [1:0] st_q;
   reg [1:0] st_d;
   reg wr_q;
   reg [5:0] dw_q;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;
   wire [5:0] rd_dw;
   wire in_idle;
   wire in_data;
   wire in_turn;
   assign in_idle = (st_q == ST_IDLE);
   assign in_data = (st_q == ST_DATA);
   assign in_turn = (st_q == ST_TURN);

   // Only configuration cycles with our IDSEL line are claimed
   wire hit = ~frame_n_i & idsel_i &
              ((cbe_n_i == `PIS_CMD_CFG_RD) | (cbe_n_i == `PIS_CMD_CFG_WR)) &
              (ad_i[1:0] == 2'b00);
   wire take;
   assign take = in_idle & hit;

   // Read data follows the address as it is taken, so the first data
   // phase already drives the addressed dword
   assign rd_dw = take ? ad_i[7:2] : dw_q;

   always @* begin
      case (rd_dw)
         `PIS_CFG_CTRL_DW: rdata_d = {{(32-`PIS_CTRL_W){1'b0}}, ctrl_q};
         `PIS_CFG_PEND_LO_DW: rdata_d = apic_pend_q[31:0];
         `PIS_CFG_PEND_HI_DW: rdata_d = {16'h0, apic_pend_q[47:32]};
         `PIS_CFG_ISA_DW: rdata_d = {16'h0, isa_pend_q};
         default: rdata_d = 32'h0;
      endcase
   end

   // Byte-lane write enables for the control dword
   wire ctrl_wr;
   wire [1:0] lane_we;
   assign ctrl_wr = in_data & ~irdy_n_i & wr_q &
                    (dw_q == `PIS_CFG_CTRL_DW);
   assign lane_we = {~cbe_n_i[1], ~cbe_n_i[0]} & {2{ctrl_wr}};

   always @* begin
      ctrl_d = ctrl_q;
      if (lane_we[0]) begin
         ctrl_d[7:0] = ad_i[7:0];
      end
      if (lane_we[1]) begin
         ctrl_d[`PIS_CTRL_W-1:8] = ad_i[`PIS_CTRL_W-1:8];
      end
   end

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (hit) begin
               st_d = ST_DATA;
            end
         end
         ST_DATA: begin
            if (~irdy_n_i) begin
               st_d = ST_TURN;
            end
         end
         ST_TURN: begin
            st_d = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_q <= ST_IDLE;
         ctrl_q <= CTRL_RST[`PIS_CTRL_W-1:0];
      end else begin
         st_q <= st_d;
         ctrl_q <= ctrl_d;
      end
   end

   // Address phase capture and read data register
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         wr_q <= 1'b0;
         dw_q <= 6'h0;
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= rdata_d;
         if (take) begin
            wr_q <= cbe_n_i[0];
            dw_q <= ad_i[7:2];
         end
      end
   end

   // Target only; the bus request is never raised, arbitration idle
   assign req_n_o = 1'b1;
   assign devsel_n_o = ~in_data;
   assign trdy_n_o = ~in_data;
   assign ctl_oe_o = in_data | in_turn;
   assign ad_oe_o = in_data & ~wr_q;
   assign ad_o = rdata_q;
endmodule

/* rtl/pis_sync.v */
`timescale 1ns/10ps
// Two-stage synchroniser for a vector of pins
module pis_sync #(
   parameter W = 1
) (
   input wire sys_clk_i,
   input wire srst_i,
   input wire [W-1:0] async_i,
   input wire [W-1:0] rst_val_i,
   output reg [W-1:0] sync_o
);
   reg [W-1:0] meta_q;
   // Reset value is a constant tie-off from the instance
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         meta_q <= rst_val_i;
         sync_o <= rst_val_i;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

/* verification/pis_src.sv */
`timescale 1ns/10ps
// Two sources share each line through open-drain drivers with pull-up
module pis_src (
   input wire [47:0] req_a_i,
   input wire [47:0] req_b_i,
   output wire [47:0] int_n_o
);
   assign int_n_o = ~(req_a_i | req_b_i);
endmodule

/* verification/pis_steer_chk.sv */
`timescale 1ns/10ps
module pis_chk (
   input wire sys_clk_i,
   input wire srst_i,
   input wire frame_n_i,
   input wire idsel_i,
   input wire [3:0] cbe_n_i,
   input wire [31:0] ad_i,
   input wire [47:0] pci_int_n_i,
   input wire [15:0] isa_irq_i,
   input wire ad_oe_o,
   input wire trdy_n_o,
   input wire devsel_n_o,
   input wire req_n_o,
   input wire intr_o,
   input wire [47:0] apic_pend_o,
   input wire [15:0] isa_pend_o,
   input wire smi_o,
   input wire nmi_o
);
   reg [2:0] up_q;
   wire ok = up_q[2];
   // Pin history is only meaningful once the syncs have refilled
   always @(posedge sys_clk_i) begin
      if (srst_i) up_q <= 3'h0;
      else if (!ok) up_q <= up_q + 3'h1;
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   chk_req_idle: assert property (req_n_o)
      else $error("bus request seen");
   chk_isa_map: assert property (ok |->
      isa_pend_o == ($past(isa_irq_i, 3) ^ 16'h0100)) else $error("isa");
   chk_apic_src: assert property (ok |->
      (apic_pend_o & $past(pci_int_n_i, 3)) == 48'h0) else $error("apic");
   chk_unused_in: assert property (!apic_pend_o[47])
      else $error("input 47 pending");
   chk_style_excl: assert property (intr_o |-> apic_pend_o == 48'h0)
      else $error("both styles");
   chk_cfg_claim: assert property (!frame_n_i && idsel_i && devsel_n_o &&
      cbe_n_i == 4'ha && ad_i[1:0] == 2'h0 |=> !devsel_n_o) else $error("claim");
   chk_no_sel: assert property (!frame_n_i && !idsel_i |=> devsel_n_o)
      else $error("claim without select");
   chk_trdy_pair: assert property (trdy_n_o == devsel_n_o)
      else $error("trdy/devsel");
   chk_oe_data: assert property (ad_oe_o |-> !trdy_n_o)
      else $error("ad driven outside data");
   chk_reset_quiet: assert property (!ok |-> !smi_o && !nmi_o)
      else $error("routed after reset");
   cover property (ad_oe_o && !trdy_n_o);
   cover property (smi_o);
   cover property (nmi_o);
endmodule
bind pis_steer pis_chk i_chk (.sys_clk_i, .srst_i, .frame_n_i, .idsel_i,
   .cbe_n_i, .ad_i, .pci_int_n_i, .isa_irq_i, .ad_oe_o, .trdy_n_o,
   .devsel_n_o, .req_n_o, .intr_o, .apic_pend_o, .isa_pend_o, .smi_o, .nmi_o);

/* verification/tb.sv */
`timescale 1ns/10ps
`include "pis_map.vh"
module tb;
   reg clk = 0, srst = 1, frame_n = 1, irdy_n = 1, idsel = 0;
   reg [3:0] cbe_n = 4'hf;
   reg [31:0] ad = 32'h0, rd;
   reg [15:0] isa = 16'h0100;
   reg [47:0] ra = 48'h0, rb = 48'h0;
   reg [5:0] ev = 6'h0;
   reg [63:0] tab = 64'h2008021008040100;
   integer n_mismatch = 0, num_checks = 0, cyc = 0, k;
   wire [31:0] ad_o;
   wire [47:0] pin_n, apic;
   wire [15:0] isap;
   wire oe, trdy_n, dsel_n, req_n, intr, smi, nmi, ctl_oe;
   pis_src i_src (.req_a_i(ra), .req_b_i(rb), .int_n_o(pin_n));
   pis_steer i_dut (.sys_clk_i(clk), .srst_i(srst), .frame_n_i(frame_n),
      .irdy_n_i(irdy_n), .idsel_i(idsel), .cbe_n_i(cbe_n), .ad_i(ad),
      .ad_o(ad_o), .ad_oe_o(oe), .trdy_n_o(trdy_n), .devsel_n_o(dsel_n),
      .ctl_oe_o(ctl_oe), .gnt_n_i(1'b1), .req_n_o(req_n),
      .pci_int_n_i(pin_n),
      .isa_irq_i(isa), .pci_serr_n_i(~ev[0]), .pci_perr_n_i(~ev[1]),
      .ecc_corr_i(ev[2]), .ecc_uncorr_i(ev[3]), .sb_smi_n_i(~ev[4]),
      .mgmt_smi_n_i(~ev[5]), .intr_o(intr), .apic_pend_o(apic),
      .isa_pend_o(isap), .smi_o(smi), .nmi_o(nmi));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         n_mismatch = n_mismatch + 1;
         tally_and_finish;
      end
   end
   task cmp(input [63:0] nm, input [47:0] e, input [47:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   // One config cycle; entered 1 ns after an edge
   task cfg(input wr, input sel, input [5:0] dw, input [31:0] wd);
      integer w;
      begin
         frame_n = 0;
         idsel = sel;
         cbe_n = wr ? `PIS_CMD_CFG_WR : `PIS_CMD_CFG_RD;
         ad = {24'h0, dw, 2'h0};
         tick(1);
         frame_n = 1;
         idsel = 0;
         irdy_n = 0;
         cbe_n = 4'h0;
         ad = wr ? wd : ~ad;
         w = 0;
         @(posedge clk);
         while (trdy_n && w < 4) begin
            w = w + 1;
            @(posedge clk);
         end
         rd = ad_o;
         cmp("claim", sel, !trdy_n);
         #1;
         irdy_n = 1;
         cbe_n = 4'hf;
         cmp("ctl_oe", sel, ctl_oe);
         tick(2);
      end
   endtask
   task t_reset;
      begin
         cmp("smi", 0, smi);
         cmp("nmi", 0, nmi);
         cmp("req_n", 1, req_n);
         cfg(0, 1, `PIS_CFG_CTRL_DW, 0);
         cmp("ctrl", `PIS_CTRL_RST, rd);
         $display("t_reset done");
      end
   endtask
   task t_isa;
      begin
         isa = 16'ha0c5;
         ra[20] = 1;
         tick(4);
         cmp("isa", 16'ha1c5, isap);
         cmp("intr", 1, intr);
         cmp("apic", 0, apic);
         cfg(0, 1, `PIS_CFG_ISA_DW, 0);
         cmp("isa_rd", 16'ha1c5, rd[15:0]);
         isa = 16'h0100;
         ra = 0;
         $display("t_isa done");
      end
   endtask
   task t_apic;
      begin
         cfg(1, 1, `PIS_CFG_CTRL_DW, 1);
         ra = 48'ha004_0000_0011;
         rb = 48'h0000_0010_0010;
         tick(4);
         cmp("apic", 48'h2004_0010_0011, apic);
         cmp("intr", 0, intr);
         cfg(0, 1, `PIS_CFG_PEND_HI_DW, 0);
         cmp("pend_hi", 16'h2004, rd[15:0]);
         ra = 0;
         tick(4);
         cmp("shared", 48'h0000_0010_0010, apic);
         rb = 0;
         tick(4);
         cmp("clear", 0, apic);
         $display("t_apic done");
      end
   endtask
   task t_route;
      begin
         cfg(1, 1, `PIS_CFG_CTRL_DW, 0);
         ev = 6'h3f;
         ra[46] = 1;
         tick(4);
         cmp("smi_off", 0, smi);
         cmp("nmi_off", 0, nmi);
         for (k = 0; k < 8; k = k + 1) begin
            ev = 0;
            ra = 0;
            cfg(1, 1, `PIS_CFG_CTRL_DW, 32'h2 << k);
            ev = tab[8*k +: 6];
            ra[46] = (k == 0);
            tick(4);
            cmp("smi", k < 5, smi);
            cmp("nmi", k > 4, nmi);
         end
         ev = 0;
         ra = 0;
         $display("t_route done");
      end
   endtask
   task t_sel;
      begin
         cfg(0, 0, `PIS_CFG_CTRL_DW, 0);
         cfg(0, 1, 6'h3f, 0);
         cmp("unmapped", 0, rd);
         $display("t_sel done");
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      tick(10);
      srst = 0;
      tick(6);
      t_reset;
      t_isa;
      t_apic;
      t_route;
      t_sel;
      tally_and_finish;
   end
endmodule
